// ===== design/timer_pwm_pkg.sv
// shared constants and types for the pwm timer
package timer_pwm_pkg;

    // ----------------------------------------------------------------
    // register byte offsets
    // ----------------------------------------------------------------
    localparam logic [4:0] REG_START = 5'h00;
    localparam logic [4:0] REG_MODE = 5'h04;
    localparam logic [4:0] REG_VALUE = 5'h08;
    localparam logic [4:0] REG_TRIG = 5'h0C;
    localparam logic [4:0] REG_PRESC = 5'h10;
    localparam logic [4:0] REG_STATUS = 5'h14;

    // ----------------------------------------------------------------
    // field positions
    // ----------------------------------------------------------------
    localparam int RUN_BIT = 0;
    localparam int MODE_EIGHT_BIT = 0;
    localparam int MODE_TRIG_CFG = 1;
    localparam int MODE_SRC_LSB = 2;
    localparam int ST_COUNTING_BIT = 0;
    localparam int ST_PULSE_BIT = 1;
    localparam int ST_ARMED_BIT = 2;

    // ----------------------------------------------------------------
    // counts
    // ----------------------------------------------------------------
    localparam logic [15:0] PHASE16_TOP = 16'hFFFE;
    localparam logic [15:0] PHASE8_TOP = 16'h00FE;
    localparam logic [2:0] EIGHTH_LAST = 3'h7;
    localparam int SUB_DIV_DEF = 32;

    // ----------------------------------------------------------------
    // types
    // ----------------------------------------------------------------
    typedef enum logic [1:0] {
        SRC_UNDIV,
        SRC_EIGHTH,
        SRC_PRESC,
        SRC_SUB32
    } src_t;

    localparam logic [1:0] TRIG_PIN = 2'h0;
    localparam logic [1:0] TRIG_NEIGH = 2'h1;
    localparam logic [1:0] TRIG_OTHER_A = 2'h2;
    localparam logic [1:0] TRIG_OTHER_B = 2'h3;

    typedef enum logic [1:0] {
        ST_STOP,
        ST_ARMED,
        ST_RUN
    } run_state_t;

    typedef struct packed {
        logic read;
        logic write;
        logic [4:0] address;
        logic [31:0] writedata;
    } avm_req_t;

endpackage

// ===== design/timer_pwm.sv
// pwm mode timer with avalon-mm register slave
//
// Operation
// R1: counter counts down on count source ticks
// R2: sixteen-bit or eight-bit with eight-bit prescale
// R3: rising output edge reloads counter, counting continues
// R4: triggers during counting are ignored
// R5: sixteen-bit high time is n ticks
// R6: sixteen-bit period is 65535 ticks
// R7: eight-bit high time is n times (m+1)
// R8: eight-bit period is 255 times (m+1)
// R9: software puts m in low byte
// R10: software puts n in high byte
// R11: run flag plus trigger starts counting
// R12: clearing run flag stops counter
// R13: interrupt request on output falling edge; code raises none when clearing the run flag drops the output
// R14: value register reads back undefined
// R15: stopped write loads reload and counter
// R16: running write loads reload only
// R17: selectable count source and prescaler divide
// R18: trigger config bit used only for pin
// R19: trigger source select chooses three sources; code selects among four (pin and three timer inputs)
// R20: output pin is pulse only
// R21: zero width keeps output low
`timescale 1ns/1ps
module timer_pwm #(
    parameter int SUB_DIV = timer_pwm_pkg::SUB_DIV_DEF
) (
    input wire logic clk_sys_in,
    input wire logic rstn_in,
    input wire timer_pwm_pkg::avm_req_t avs_req_in,
    output logic [31:0] avs_readdata_out,
    output logic avs_waitrequest_out,
    input wire logic trigger_input_pin_in,
    input wire logic subclock_in,
    input wire logic neighbour_second_timer_in,
    input wire logic other_timer_a_in,
    input wire logic other_timer_b_in,
    output logic pulse_output_pin_out,
    output logic irq_req_out
);
    import timer_pwm_pkg::*;

    localparam int SW = (SUB_DIV > 1) ? $clog2(SUB_DIV) : 1;

    if (SUB_DIV < 2) begin : g_bad_sub_div
        $error("SUB_DIV must be at least 2");
    end

    // ----------------------------------------------------------------
    // registers
    // ----------------------------------------------------------------
    logic run_flag;
    logic eight_bit;
    logic trigger_config_bit;
    src_t src_sel;
    logic [1:0] trig_sel;
    logic [3:0] prescale_divider_field;
    logic [15:0] reload;

    run_state_t state;
    logic [15:0] phase;
    logic [15:0] width;
    logic [7:0] pre;
    logic [7:0] m_q;

    logic acc;
    logic wr;
    logic wr_val;
    logic [15:0] wdata16;
    logic [31:0] next_rdata;

    assign acc = (avs_req_in.read | avs_req_in.write) & ~avs_waitrequest_out;
    assign wr = acc & avs_req_in.write;
    assign wr_val = wr && (avs_req_in.address == REG_VALUE);
    assign wdata16 = avs_req_in.writedata[15:0];

    // ----------------------------------------------------------------
    // bus slave
    // ----------------------------------------------------------------
    // one wait cycle per access keeps read data off a combinational path
    always_ff @(posedge clk_sys_in or negedge rstn_in) begin
        if (!rstn_in) begin
            avs_waitrequest_out <= 1'b1;
            avs_readdata_out <= 32'h0;
        end else if ((avs_req_in.read | avs_req_in.write)
                     && avs_waitrequest_out) begin
            avs_waitrequest_out <= 1'b0;
            avs_readdata_out <= next_rdata;
        end else begin
            avs_waitrequest_out <= 1'b1;
        end
    end

    always_comb begin
        next_rdata = 32'h0;
        unique case (avs_req_in.address)
            REG_START: next_rdata[RUN_BIT] = run_flag;
            REG_MODE: begin
                next_rdata[MODE_EIGHT_BIT] = eight_bit;
                next_rdata[MODE_TRIG_CFG] = trigger_config_bit;
                next_rdata[MODE_SRC_LSB +: 2] = src_sel;
            end
            REG_TRIG: next_rdata[1:0] = trig_sel;
            REG_PRESC: next_rdata[3:0] = prescale_divider_field;
            REG_STATUS: begin
                next_rdata[ST_COUNTING_BIT] = (state == ST_RUN);
                next_rdata[ST_PULSE_BIT] = pulse_output_pin_out;
                next_rdata[ST_ARMED_BIT] = (state == ST_ARMED);
            end
            // live count is not offered; value reads as zero
            default: next_rdata = 32'h0; // R14
        endcase
    end

    always_ff @(posedge clk_sys_in or negedge rstn_in) begin
        if (!rstn_in) begin
            run_flag <= 1'b0;
            eight_bit <= 1'b0;
            trigger_config_bit <= 1'b0;
            src_sel <= SRC_UNDIV;
            trig_sel <= TRIG_PIN;
            prescale_divider_field <= 4'h0;
        end else if (wr) begin
            unique case (avs_req_in.address)
                REG_START: run_flag <= avs_req_in.writedata[RUN_BIT];
                REG_MODE: begin
                    eight_bit <= avs_req_in.writedata[MODE_EIGHT_BIT]; // R2
                    trigger_config_bit <=
                        avs_req_in.writedata[MODE_TRIG_CFG];
                    src_sel <= src_t'(avs_req_in.writedata[MODE_SRC_LSB +: 2]);
                end
                REG_TRIG: trig_sel <= avs_req_in.writedata[1:0];
                REG_PRESC: prescale_divider_field <=
                    avs_req_in.writedata[3:0];
                default: ;
            endcase
        end
    end

    // low byte holds m, high byte n in eight-bit operation
    always_ff @(posedge clk_sys_in or negedge rstn_in) begin
        if (!rstn_in) begin
            reload <= 16'h0;
        end else if (wr_val) begin
            reload <= wdata16; // R9 R10 R15 R16
        end
    end

    // ----------------------------------------------------------------
    // synchronisers
    // ----------------------------------------------------------------
    logic pin_s1;
    logic pin_s2;
    logic pin_s3;
    logic sub_s1;
    logic sub_s2;
    logic sub_s3;

    always_ff @(posedge clk_sys_in or negedge rstn_in) begin
        if (!rstn_in) begin
            pin_s1 <= 1'b0;
            pin_s2 <= 1'b0;
            pin_s3 <= 1'b0;
            sub_s1 <= 1'b0;
            sub_s2 <= 1'b0;
            sub_s3 <= 1'b0;
        end else begin
            pin_s1 <= trigger_input_pin_in;
            pin_s2 <= pin_s1;
            pin_s3 <= pin_s2;
            sub_s1 <= subclock_in;
            sub_s2 <= sub_s1;
            sub_s3 <= sub_s2;
        end
    end

    // ----------------------------------------------------------------
    // count source
    // ----------------------------------------------------------------
    logic [2:0] div8;
    logic [4:0] pcnt;
    logic [SW-1:0] scnt;
    logic tick_presc;
    logic tick_sub;
    logic tick;

    assign tick_presc = (prescale_divider_field == 4'h0)
        || (pcnt == {prescale_divider_field, 1'b0} - 5'h01);
    assign tick_sub = sub_s2 && !sub_s3
        && (scnt == SW'(SUB_DIV - 1));

    always_ff @(posedge clk_sys_in or negedge rstn_in) begin
        if (!rstn_in) begin
            div8 <= 3'h0;
            pcnt <= 5'h00;
            scnt <= '0;
        end else begin
            div8 <= div8 + 3'h1;
            pcnt <= tick_presc ? 5'h00 : pcnt + 5'h01;
            if (sub_s2 && !sub_s3) begin
                scnt <= tick_sub ? '0 : scnt + SW'(1);
            end
        end
    end

    always_comb begin
        unique case (src_sel)
            SRC_UNDIV: tick = 1'b1; // R17
            SRC_EIGHTH: tick = (div8 == EIGHTH_LAST); // R17
            SRC_PRESC: tick = tick_presc; // R17
            SRC_SUB32: tick = tick_sub; // R17
        endcase
    end

    // ----------------------------------------------------------------
    // trigger
    // ----------------------------------------------------------------
    logic pin_edge;
    logic trig;

    // config bit high picks the rising pin edge, low the falling one
    assign pin_edge = trigger_config_bit ? (pin_s2 && !pin_s3)
                                         : (!pin_s2 && pin_s3);

    always_comb begin
        unique case (trig_sel)
            TRIG_PIN: trig = pin_edge; // R18 R19 R20
            TRIG_NEIGH: trig = neighbour_second_timer_in; // R19
            TRIG_OTHER_A: trig = other_timer_a_in; // R19
            TRIG_OTHER_B: trig = other_timer_b_in; // R19
        endcase
    end

    // ----------------------------------------------------------------
    // modulator
    // ----------------------------------------------------------------
    logic step;
    logic [15:0] cur_w;
    logic [7:0] cur_m;
    logic fall_evt;

    assign cur_w = eight_bit ? {8'h00, reload[15:8]} : reload;
    assign cur_m = reload[7:0];
    assign step = eight_bit ? (tick && pre == 8'h00) : tick; // R2 R7
    assign fall_evt = state == ST_RUN && run_flag && step
        && phase != 16'h0 && pulse_output_pin_out && width < 16'h0002;

    always_ff @(posedge clk_sys_in or negedge rstn_in) begin
        if (!rstn_in) begin
            state <= ST_STOP;
            phase <= 16'h0;
            width <= 16'h0;
            pre <= 8'h00;
            m_q <= 8'h00;
            pulse_output_pin_out <= 1'b0;
        end else begin
            unique case (state)
                ST_STOP: begin
                    pulse_output_pin_out <= 1'b0;
                    if (wr_val) begin
                        width <= eight_bit ? {8'h00, wdata16[15:8]}
                                           : wdata16; // R15
                    end
                    if (run_flag) begin
                        state <= ST_ARMED;
                    end
                end
                ST_ARMED: begin
                    if (!run_flag) begin
                        state <= ST_STOP; // R12
                    end else if (trig) begin
                        state <= ST_RUN; // R11
                        phase <= eight_bit ? PHASE8_TOP : PHASE16_TOP;
                        width <= cur_w;
                        pre <= cur_m;
                        m_q <= cur_m;
                        pulse_output_pin_out <= (cur_w != 16'h0); // R21
                    end
                end
                ST_RUN: begin
                    if (!run_flag) begin
                        state <= ST_STOP; // R12
                        pulse_output_pin_out <= 1'b0;
                    end else begin // R4
                        // trig is not looked at here
                        if (eight_bit && tick) begin
                            pre <= (pre == 8'h00) ? m_q : pre - 8'h01;
                        end
                        if (step && phase == 16'h0) begin
                            // R3 R6 R8
                            phase <= eight_bit ? PHASE8_TOP : PHASE16_TOP;
                            width <= cur_w; // R3 R16
                            pre <= cur_m;
                            m_q <= cur_m;
                            pulse_output_pin_out <= (cur_w != 16'h0); // R21
                        end else if (step) begin
                            phase <= phase - 16'h0001; // R1
                            if (width != 16'h0) begin
                                width <= width - 16'h0001; // R5 R7
                            end
                            pulse_output_pin_out <= (width > 16'h0001);
                        end
                    end
                end
                default: state <= ST_STOP;
            endcase
        end
    end

    always_ff @(posedge clk_sys_in or negedge rstn_in) begin
        if (!rstn_in) begin
            irq_req_out <= 1'b0;
        end else begin
            irq_req_out <= fall_evt; // R13
        end
    end

    // ----------------------------------------------------------------
    // assertions
    // ----------------------------------------------------------------
    default clocking cb @(posedge clk_sys_in);
    endclocking
    default disable iff (!rstn_in);

    sequence s_armed_trig;
        state == ST_ARMED && run_flag && trig;
    endsequence

    sequence s_period_start;
        state == ST_RUN && run_flag && step && phase == 16'h0;
    endsequence

    a_start_trig: assert property ( // R11
        s_armed_trig |=> state == ST_RUN && width == $past(cur_w)
    ) else $error("trigger did not start counting");

    a_stop_run: assert property ( // R12
        !run_flag && state == ST_RUN |=> state == ST_STOP
            && !pulse_output_pin_out ##1 state == ST_STOP
    ) else $error("clearing run flag did not stop");

    a_count_down: assert property ( // R1
        state == ST_RUN && run_flag && step && phase != 16'h0
            |=> phase == $past(phase) - 16'h0001
    ) else $error("counter did not step down");

    a_trig_ignored: assert property ( // R4
        state == ST_RUN && run_flag && trig && !step
            |=> $stable(phase) && $stable(pulse_output_pin_out)
    ) else $error("trigger disturbed running counter");

    a_reload_rise: assert property ( // R3
        $rose(pulse_output_pin_out) |-> width == $past(cur_w)
    ) else $error("rising edge without reload");

    a_period_16: assert property ( // R6
        s_period_start ##0 !eight_bit |=> phase == PHASE16_TOP
    ) else $error("sixteen-bit period not restarted");

    a_period_8: assert property ( // R8
        s_period_start ##0 eight_bit
            |=> phase == PHASE8_TOP && pre == $past(cur_m)
    ) else $error("eight-bit period not restarted");

    a_high_width: assert property ( // R5 R7 R21
        state == ST_RUN |-> pulse_output_pin_out == (width != 16'h0)
    ) else $error("output level disagrees with width");

    a_irq_fall: assert property ( // R13
        fall_evt |=> irq_req_out && !pulse_output_pin_out
            ##1 !irq_req_out
    ) else $error("interrupt not on falling edge");

    a_stop_load: assert property ( // R15
        wr_val && state == ST_STOP && !eight_bit
            |=> reload == $past(wdata16) && width == $past(wdata16)
    ) else $error("stopped write did not load counter");

    a_run_write: assert property ( // R16
        wr_val && state == ST_RUN && run_flag && !step
            |=> reload == $past(wdata16) && $stable(width)
    ) else $error("running write touched counter");

endmodule

// ===== sim/trig_source_model.sv
// trigger sources, subclock and pulse load around the pwm timer
`timescale 1ns/1ps
module trig_source_model (
    input wire logic clk_sys_in,
    input wire logic rstn_in,
    input wire logic fire_in,
    input wire logic [1:0] sel_in,
    input wire logic pulse_in,
    output logic pin_out,
    output logic neighbour_out,
    output logic other_a_out,
    output logic other_b_out,
    output logic subclock_out
);
    logic [2:0] pin_hold;
    logic [1:0] sub_cnt;
    logic pulse_q;
    int load_rises;

    // pin idles low as if pulled down; a pin trigger is a 4-cycle high
    assign pin_out = (pin_hold != 3'h0);
    assign subclock_out = sub_cnt[1];

    always_ff @(posedge clk_sys_in or negedge rstn_in) begin
        if (!rstn_in) begin
            neighbour_out <= 1'b0;
            other_a_out <= 1'b0;
            other_b_out <= 1'b0;
            pin_hold <= 3'h0;
            sub_cnt <= 2'h0;
            pulse_q <= 1'b0;
            load_rises <= 0;
        end else begin
            neighbour_out <= fire_in && (sel_in == 2'h1);
            other_a_out <= fire_in && (sel_in == 2'h2);
            other_b_out <= fire_in && (sel_in == 2'h3);
            if (fire_in && (sel_in == 2'h0)) begin
                pin_hold <= 3'h4;
            end else if (pin_hold != 3'h0) begin
                pin_hold <= pin_hold - 3'h1;
            end
            sub_cnt <= sub_cnt + 2'h1;
            pulse_q <= pulse_in;
            if (pulse_in && !pulse_q) begin
                load_rises <= load_rises + 1;
            end
        end
    end
endmodule

// ===== sim/test_timer_pwm.sv
// self-checking bench for the pwm timer
`timescale 1ns/1ps
module test_timer_pwm;
    import timer_pwm_pkg::*;
    logic clk_sys_in;
    logic rstn_in;
    avm_req_t req;
    logic [31:0] readdata;
    logic waitrequest;
    logic pin, neigh, oth_a, oth_b, subclk, pulse, irq;
    logic fire;
    logic [1:0] fsel;
    logic [7:0] lfsr;
    logic [7:0] nb;
    logic [31:0] rd;
    int fail_count;
    int n_compared;
    int hits;
    int irqs;
    int r0;
    int ref_q[$];
    int dv[4] = '{1, 8, 6, 8};

    timer_pwm #(.SUB_DIV(2)) timer_pwm_i (
        .clk_sys_in(clk_sys_in), .rstn_in(rstn_in), .avs_req_in(req),
        .avs_readdata_out(readdata), .avs_waitrequest_out(waitrequest),
        .trigger_input_pin_in(pin), .subclock_in(subclk),
        .neighbour_second_timer_in(neigh), .other_timer_a_in(oth_a),
        .other_timer_b_in(oth_b), .pulse_output_pin_out(pulse),
        .irq_req_out(irq));
    trig_source_model trig_source_model_i (
        .clk_sys_in(clk_sys_in), .rstn_in(rstn_in), .fire_in(fire),
        .sel_in(fsel), .pulse_in(pulse), .pin_out(pin),
        .neighbour_out(neigh), .other_a_out(oth_a), .other_b_out(oth_b),
        .subclock_out(subclk));

    // ----------------------------------------------------------------
    // checking and bus tasks
    // ----------------------------------------------------------------
    function automatic logic [7:0] lfsr_next(input logic [7:0] s);
        return {s[6:0], s[7] ^ s[5] ^ s[4] ^ s[3]};
    endfunction
    task fail(input string what);
        fail_count++;
        $display("[FAIL] %0t %s", $time, what);
    endtask
    task chk_count(input int got, input int exp, input string what);
        n_compared++;
        if (got != exp) fail($sformatf("%s got %0d exp %0d", what, got, exp));
    endtask
    task chk_word(input logic [31:0] got, input logic [31:0] exp,
                  input string what);
        n_compared++;
        if (got !== exp) fail($sformatf("%s got %h exp %h", what, got, exp));
    endtask
    // reference model: high time and period in clocks for one value word
    task ref_push(input logic [15:0] v, input bit eight, input int d);
        int m;
        begin
            m = int'(v[7:0]) + 1;
            if (eight) begin
                ref_q.push_back(int'(v[15:8]) * m * d);
                ref_q.push_back(255 * m * d);
            end else begin
                ref_q.push_back(int'(v) * d);
                ref_q.push_back(65535 * d);
            end
        end
    endtask
    task avm_write(input logic [4:0] a, input logic [31:0] d);
        int k;
        begin
            @(posedge clk_sys_in);
            req.write <= 1'b1;
            req.address <= a;
            req.writedata <= d;
            k = 0;
            do begin
                @(posedge clk_sys_in);
                k++;
            end while (waitrequest !== 1'b0 && k < 50);
            req.write <= 1'b0;
            if (k >= 50) fail("write not answered");
        end
    endtask
    task avm_read(input logic [4:0] a, output logic [31:0] d);
        int k;
        begin
            @(posedge clk_sys_in);
            req.read <= 1'b1;
            req.address <= a;
            k = 0;
            do begin
                @(posedge clk_sys_in);
                k++;
            end while (waitrequest !== 1'b0 && k < 50);
            d = readdata;
            req.read <= 1'b0;
            if (k >= 50) fail("read not answered");
        end
    endtask
    task start(input logic [3:0] mode, input logic [1:0] trg,
               input logic [3:0] psc, input logic [15:0] val);
        avm_write(REG_START, 32'h0);
        avm_write(REG_MODE, {28'h0, mode});
        avm_write(REG_TRIG, {30'h0, trg});
        avm_write(REG_PRESC, {28'h0, psc});
        avm_write(REG_VALUE, {16'h0, val});
        avm_write(REG_START, 32'h1);
    endtask
    task shoot(input logic [1:0] s);
        @(posedge clk_sys_in);
        fsel <= s;
        fire <= 1'b1;
        @(posedge clk_sys_in);
        fire <= 1'b0;
    endtask
    // expected widths come from the reference queue; chk low skips checks
    task measure(input bit chk, input bit poke);
        int h, l, k, eh, ep;
        begin
            h = 0;
            l = 0;
            k = 0;
            eh = 0;
            ep = 0;
            if (chk) begin
                eh = ref_q.pop_front();
                ep = ref_q.pop_front();
            end
            while (pulse !== 1'b1 && k < 200) begin
                @(negedge clk_sys_in);
                k++;
            end
            while (pulse === 1'b1 && h < 70000) begin
                fsel = TRIG_NEIGH;
                fire = poke && (h == 2);
                h++;
                @(negedge clk_sys_in);
            end
            fire = 1'b0;
            if (chk) chk_word({31'h0, irq}, 32'h1, "irq at fall");
            while (pulse !== 1'b1 && l < 70000) begin
                l++;
                @(negedge clk_sys_in);
            end
            if (chk) begin
                chk_count(h, eh, "high width");
                chk_count(h + l, ep, "period");
            end
        end
    endtask
    task watch(input int skip);
        hits = 0;
        irqs = 0;
        for (int k = 0; k < 300; k++) begin
            @(negedge clk_sys_in);
            if (irq === 1'b1) irqs++;
            if (k >= skip && pulse !== 1'b0) hits++;
        end
    endtask
    task complete_run;
        $display("compared %0d mismatches %0d", n_compared, fail_count);
        if (fail_count == 0 && n_compared > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask

    // ----------------------------------------------------------------
    // clock, watchdog and tests
    // ----------------------------------------------------------------
    initial begin
        clk_sys_in = 1'b0;
        forever #10 clk_sys_in = ~clk_sys_in;
    end
    // the run takes some 81k cycles, 66k of them the 16-bit period
    initial begin
        repeat (95000) @(posedge clk_sys_in);
        fail("watchdog expired");
        complete_run();
    end
    initial begin
        req = '0;
        fire = 1'b0;
        fsel = 2'h0;
        rstn_in = 1'b0;
        lfsr = 8'h56;
        fail_count = 0;
        n_compared = 0;
        repeat (16) @(posedge clk_sys_in);
        rstn_in <= 1'b1;
        start(4'h1, TRIG_NEIGH, 4'h0, 16'h0500);
        ref_push(16'h0500, 1'b1, 1);
        ref_push(16'h0500, 1'b1, 1);
        shoot(TRIG_NEIGH);
        measure(1'b1, 1'b0);
        measure(1'b1, 1'b1);
        avm_write(REG_VALUE, 32'h0000_0900);
        measure(1'b0, 1'b0);
        ref_push(16'h0900, 1'b1, 1);
        measure(1'b1, 1'b0);
        avm_read(REG_VALUE, rd);
        chk_word(rd, 32'h0, "value readback");
        avm_read(5'h18, rd);
        chk_word(rd, 32'h0, "unmapped read");
        $display("test basic done");
        start(4'h3, TRIG_NEIGH, 4'h0, 16'h0302);
        shoot(TRIG_NEIGH);
        ref_push(16'h0302, 1'b1, 1);
        measure(1'b1, 1'b1);
        $display("test prescale done");
        for (int s = 1; s < 4; s++) begin
            start({2'(s), 2'b01}, TRIG_NEIGH, 4'h3, 16'h0300);
            shoot(TRIG_NEIGH);
            // writes 3 cycles apart: at least one lands between steps
            avm_write(REG_VALUE, 32'h0000_0200);
            avm_write(REG_VALUE, 32'h0000_0300);
            // the first period starts off the source tick; use the next
            measure(1'b0, 1'b0);
            ref_push(16'h0300, 1'b1, dv[s]);
            measure(1'b1, 1'b0);
        end
        $display("test sources done");
        for (int s = 0; s < 4; s++) begin
            lfsr = lfsr_next(lfsr);
            nb = (lfsr % 8'd40) + 8'd1;
            start(4'h3, 2'(s), 4'h0, {nb, 8'h00});
            shoot(2'(s + 1));
            repeat (10) @(negedge clk_sys_in);
            chk_word({31'h0, pulse}, 32'h0, "wrong trigger");
            shoot(2'(s));
            ref_push({nb, 8'h00}, 1'b1, 1);
            measure(1'b1, 1'b0);
        end
        $display("test triggers done");
        start(4'h1, TRIG_NEIGH, 4'h0, 16'h0000);
        shoot(TRIG_NEIGH);
        r0 = trig_source_model_i.load_rises;
        watch(0);
        chk_count(hits, 0, "zero width high");
        chk_count(irqs, 0, "zero width irq");
        chk_count(trig_source_model_i.load_rises - r0, 0, "zero rise");
        $display("test zero done");
        start(4'h1, TRIG_PIN, 4'h0, 16'hC800);
        shoot(TRIG_PIN);
        repeat (5) @(negedge clk_sys_in);
        chk_word({31'h0, pulse}, 32'h0, "rising pin took");
        repeat (5) @(negedge clk_sys_in);
        chk_word({31'h0, pulse}, 32'h1, "started high");
        avm_write(REG_START, 32'h0);
        watch(2);
        chk_count(hits, 0, "stopped high");
        chk_count(irqs, 0, "stopped irq");
        $display("test stop done");
        start(4'h0, TRIG_NEIGH, 4'h0, 16'hFFFE);
        shoot(TRIG_NEIGH);
        ref_push(16'hFFFE, 1'b0, 1);
        measure(1'b1, 1'b0);
        $display("test wide done");
        complete_run();
    end
endmodule
